/* core/mcr_top.sv */
// monitor control registers, clock divider and multi-byte result presentation
`timescale 1ns/100ps
`include "mcr_cfg.svh"
// How it works
// - attention flag sets on alert or written 1, clears only on written 0
// - pin 3 in attention mode pulls low while flag set; otherwise flag ignored
// - pin 3 as general output pulls low when pull-down bit is 1, else Hi-Z
// - system tick divides external clock by four times divider integer, reset 00100
// - 12-bit values read as high byte bits 11..4, low byte bits 3..0 then zeros
// - 24-bit power values read as three bytes, most significant first
// - 32-bit time, charge and energy values read as four bytes, msb first
// - timer lsb time is N times 4 times divider over clock, or N times 4us
// - N follows the timing fields; low field 110 gives 4098.5 regardless
module mcr_top #(
    parameter logic [15:0] SPECIAL_IDENT = 16'h5a5a // arbitrary value
) (
    input wire logic mclk_i, // 10 MHz block clock
    input wire logic reset_i, // synchronous active-high reset
    input wire logic [7:0] reg_addr_i, // register address
    input wire logic reg_wr_i, // register write strobe
    input wire logic reg_rd_i, // register read strobe
    input wire logic [7:0] reg_wdata_i, // register write data
    output logic [7:0] reg_rdata_o, // register read data
    output logic reg_rvalid_o, // read data valid pulse
    input wire logic alert_event_i, // alert condition pulse
    input wire mcr_pkg::mcr_pin3_mode_type pin3_mode_i, // pin 3 configuration
    input wire logic pin3_i, // pin 3 level, unused by this block's logic
    output logic pin3_o, // pin 3 drive level, always low
    output logic pin3_oe_o, // pin 3 pull-down enable
    input wire logic ext_clock_in_i, // external time base, sampled
    input wire logic use_int_osc_i, // select internal oscillator
    input wire logic int_osc_tick_i, // internal 250 kHz tick pulse
    output logic sys_tick_o, // system clock tick pulse
    input wire logic [1:0] conv_timing_hi_i, // converter timing high field
    input wire logic [2:0] conv_timing_lo_i, // converter timing low field
    output logic [25:0] n_factor_o, // timer factor n times 10000
    output logic [33:0] lsb_time_o, // n*4*div or n*4 scaled by 10000
    input wire logic [11:0] conv_value_i, // 12-bit converter result
    input wire logic [23:0] power_value_i, // 24-bit power result
    input wire logic [31:0] accum_value_i // 32-bit accumulator
);
    import mcr_pkg::*;

    logic attn_flag_bit;
    logic pin3_pulldown_bit;
    logic [4:0] divider_integer;
    logic ext_q;
    logic [6:0] div_cnt;
    logic [7:0] conv_shadow;
    logic [15:0] power_shadow;
    logic [23:0] accum_shadow;

    // reset image of the control register, indexed per field below
    localparam logic [7:0] CTRL_RESET = `MCR_PIN3_CONTROL_RESET;

    // one select per mapped address; unmapped addresses select nothing
    wire sel_ctrl = (reg_addr_i == `MCR_ADDR_PIN3_CONTROL);
    wire sel_div = (reg_addr_i == `MCR_ADDR_CLOCK_DIVIDER);
    wire sel_conv_hi = (reg_addr_i == `MCR_ADDR_CONV_HIGH);
    wire sel_conv_lo = (reg_addr_i == `MCR_ADDR_CONV_LOW);
    wire sel_power_b2 = (reg_addr_i == `MCR_ADDR_POWER_B2);
    wire sel_power_b1 = (reg_addr_i == `MCR_ADDR_POWER_B1);
    wire sel_power_b0 = (reg_addr_i == `MCR_ADDR_POWER_B0);
    wire sel_accum_b3 = (reg_addr_i == `MCR_ADDR_ACCUM_B3);
    wire sel_accum_b2 = (reg_addr_i == `MCR_ADDR_ACCUM_B2);
    wire sel_accum_b1 = (reg_addr_i == `MCR_ADDR_ACCUM_B1);
    wire sel_accum_b0 = (reg_addr_i == `MCR_ADDR_ACCUM_B0);
    wire sel_ident_hi = (reg_addr_i == `MCR_ADDR_IDENT_HIGH);
    wire sel_ident_lo = (reg_addr_i == `MCR_ADDR_IDENT_LOW);

    wire wr_ctrl = reg_wr_i && sel_ctrl;
    wire wr_div = reg_wr_i && sel_div;
    wire rd_conv_hi = reg_rd_i && sel_conv_hi;
    wire rd_power_hi = reg_rd_i && sel_power_b2;
    wire rd_accum_hi = reg_rd_i && sel_accum_b3;

    // write data fields; reserved bit positions are never stored
    wire wr_attn_bit = reg_wdata_i[`MCR_ATTN_FLAG_POS];
    wire wr_pulldown_bit = reg_wdata_i[`MCR_PULLDOWN_POS];
    wire [4:0] wr_divider = reg_wdata_i[`MCR_DIV_MSB:0];

    // the event outranks a clearing write in the same cycle
    wire next_attn_flag = alert_event_i
        || (wr_ctrl && wr_attn_bit)
        || (attn_flag_bit && !wr_ctrl);

    // pull-down follows the mode; flag or control bit act only in their own mode
    wire next_pin3_oe = ((pin3_mode_i == MCR_PIN3_ATTN_OUT) && attn_flag_bit)
        || ((pin3_mode_i == MCR_PIN3_GP_OUT) && pin3_pulldown_bit);

    // a zero divider is run as a divider of one, so the external clock is divided by four
    wire [4:0] div_eff = (divider_integer == 5'h00) ? 5'h01 : divider_integer;
    wire [6:0] div_limit = 7'({2'h0, div_eff} * `MCR_DIV_FACTOR);
    wire ext_rise = ext_clock_in_i && !ext_q;
    wire div_wrap = ext_rise && (div_cnt == 7'(div_limit - 7'h01));
    wire next_sys_tick = use_int_osc_i ? int_osc_tick_i : div_wrap;

    function automatic logic [25:0] n_lookup(input logic [1:0] hi, input logic [2:0] lo);
        logic [25:0] n;
        n = `MCR_N_LO110;
        if (lo == 3'h6 || lo == 3'h7)
        begin
            n = `MCR_N_LO110;
        end
        else
        begin
            case ({hi, lo})
                5'h1b: n = `MCR_N_11_011;
                5'h1a: n = `MCR_N_11_010;
                5'h1d: n = `MCR_N_11_010;
                5'h19: n = `MCR_N_11_001;
                5'h1c: n = `MCR_N_11_001;
                5'h18: n = `MCR_N_11_000;
                5'h13: n = `MCR_N_10_011;
                5'h12: n = `MCR_N_10_010;
                5'h15: n = `MCR_N_10_010;
                5'h11: n = `MCR_N_10_001;
                5'h14: n = `MCR_N_10_001;
                5'h10: n = `MCR_N_10_000;
                5'h0b: n = `MCR_N_01_011;
                5'h0a: n = `MCR_N_01_010;
                5'h0d: n = `MCR_N_01_010;
                5'h09: n = `MCR_N_01_001;
                5'h0c: n = `MCR_N_01_001;
                5'h08: n = `MCR_N_01_000;
                5'h03: n = `MCR_N_00_011;
                5'h02: n = `MCR_N_00_010;
                5'h05: n = `MCR_N_00_010;
                5'h01: n = `MCR_N_00_001;
                5'h04: n = `MCR_N_00_001;
                default: n = `MCR_N_00_000;
            endcase
        end
        return n;
    endfunction : n_lookup

    wire [25:0] next_n = n_lookup(conv_timing_hi_i, conv_timing_lo_i);
    wire [6:0] lsb_mult = use_int_osc_i ? `MCR_DIV_FACTOR : div_limit;
    wire [33:0] next_lsb_time = 34'({8'h00, next_n} * {27'h0, lsb_mult});

    // msb reads take the live value and freeze the lower bytes for a coherent word
    wire [7:0] byte_ctrl = {attn_flag_bit, pin3_pulldown_bit, 6'h00};
    wire [7:0] byte_div = {3'h0, divider_integer};

    // byte lanes; the lower lanes of a word come from the snapshot of its msb read
    wire [7:0] conv_hi_byte = conv_value_i[11:4];
    wire [7:0] conv_lo_byte = {conv_shadow[3:0], 4'h0};
    wire [7:0] power_b2_byte = power_value_i[23:16];
    wire [7:0] power_b1_byte = power_shadow[15:8];
    wire [7:0] power_b0_byte = power_shadow[7:0];
    wire [7:0] accum_b3_byte = accum_value_i[31:24];
    wire [7:0] accum_b2_byte = accum_shadow[23:16];
    wire [7:0] accum_b1_byte = accum_shadow[15:8];
    wire [7:0] accum_b0_byte = accum_shadow[7:0];

    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = `MCR_READ_ZERO;
        if (sel_ctrl)
        begin
            next_rdata = byte_ctrl;
        end
        else if (sel_div)
        begin
            next_rdata = byte_div;
        end
        else if (sel_conv_hi)
        begin
            next_rdata = conv_hi_byte;
        end
        else if (sel_conv_lo)
        begin
            next_rdata = conv_lo_byte;
        end
        else if (sel_power_b2)
        begin
            next_rdata = power_b2_byte;
        end
        else if (sel_power_b1)
        begin
            next_rdata = power_b1_byte;
        end
        else if (sel_power_b0)
        begin
            next_rdata = power_b0_byte;
        end
        else if (sel_accum_b3)
        begin
            next_rdata = accum_b3_byte;
        end
        else if (sel_accum_b2)
        begin
            next_rdata = accum_b2_byte;
        end
        else if (sel_accum_b1)
        begin
            next_rdata = accum_b1_byte;
        end
        else if (sel_accum_b0)
        begin
            next_rdata = accum_b0_byte;
        end
        else if (sel_ident_hi)
        begin
            next_rdata = SPECIAL_IDENT[15:8];
        end
        else if (sel_ident_lo)
        begin
            next_rdata = SPECIAL_IDENT[7:0];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            attn_flag_bit <= CTRL_RESET[`MCR_ATTN_FLAG_POS];
            pin3_pulldown_bit <= CTRL_RESET[`MCR_PULLDOWN_POS];
            divider_integer <= `MCR_DIVIDER_RESET;
        end
        else
        begin
            attn_flag_bit <= next_attn_flag;
            if (wr_ctrl)
            begin
                pin3_pulldown_bit <= wr_pulldown_bit;
            end
            if (wr_div)
            begin
                divider_integer <= wr_divider;
            end
        end
    end

    // a divider write restarts the count so the first period is a full one
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            // starts high so a level already high after reset is not taken as an edge
            ext_q <= 1'b1;
            div_cnt <= 7'h00;
            sys_tick_o <= 1'b0;
        end
        else
        begin
            ext_q <= ext_clock_in_i;
            if (wr_div || div_wrap)
            begin
                div_cnt <= 7'h00;
            end
            else if (ext_rise)
            begin
                div_cnt <= 7'(div_cnt + 7'h01);
            end
            sys_tick_o <= next_sys_tick;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            conv_shadow <= 8'h00;
            power_shadow <= 16'h0000;
            accum_shadow <= 24'h000000;
        end
        else
        begin
            if (rd_conv_hi)
            begin
                conv_shadow <= {4'h0, conv_value_i[3:0]};
            end
            if (rd_power_hi)
            begin
                power_shadow <= power_value_i[15:0];
            end
            if (rd_accum_hi)
            begin
                accum_shadow <= accum_value_i[23:0];
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
            pin3_o <= 1'b0;
            pin3_oe_o <= 1'b0;
            n_factor_o <= 26'h0;
            lsb_time_o <= 34'h0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
            begin
                reg_rdata_o <= next_rdata;
            end
            pin3_o <= 1'b0;
            pin3_oe_o <= next_pin3_oe;
            n_factor_o <= next_n;
            lsb_time_o <= next_lsb_time;
        end
    end

endmodule : mcr_top

/* inc/mcr_cfg.svh */
// constants for the monitor control and result register block
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// register port addresses
`define MCR_ADDR_PIN3_CONTROL 8'h42
`define MCR_ADDR_CLOCK_DIVIDER 8'h43
`define MCR_ADDR_CONV_HIGH 8'h00
`define MCR_ADDR_CONV_LOW 8'h01
`define MCR_ADDR_POWER_B2 8'h02
`define MCR_ADDR_POWER_B1 8'h03
`define MCR_ADDR_POWER_B0 8'h04
`define MCR_ADDR_ACCUM_B3 8'h05
`define MCR_ADDR_ACCUM_B2 8'h06
`define MCR_ADDR_ACCUM_B1 8'h07
`define MCR_ADDR_ACCUM_B0 8'h08
`define MCR_ADDR_IDENT_HIGH 8'h09
`define MCR_ADDR_IDENT_LOW 8'h0a

// field positions and reset values
`define MCR_ATTN_FLAG_POS 7
`define MCR_PULLDOWN_POS 6
`define MCR_DIV_MSB 4
`define MCR_PIN3_CONTROL_RESET 8'h00
`define MCR_DIVIDER_RESET 5'h04
`define MCR_DIV_FACTOR 7'h04
`define MCR_READ_ZERO 8'h00

// timer lsb factor n, scaled by 10000
`define MCR_N_LO110 26'd40985000
`define MCR_N_11_011 26'd40997500
`define MCR_N_11_010 26'd40985098
`define MCR_N_11_001 26'd40985806
`define MCR_N_11_000 26'd40993333
`define MCR_N_10_011 26'd40997355
`define MCR_N_10_010 26'd40985097
`define MCR_N_10_001 26'd40985800
`define MCR_N_10_000 26'd40993549
`define MCR_N_01_011 26'd40996429
`define MCR_N_01_010 26'd40985092
`define MCR_N_01_001 26'd40985758
`define MCR_N_01_000 26'd40992692
`define MCR_N_00_011 26'd40990000
`define MCR_N_00_010 26'd40985049
`define MCR_N_00_001 26'd40985397
`define MCR_N_00_000 26'd40988571

`endif

/* inc/mcr_pkg.sv */
// types shared by the monitor control and result register block
package mcr_pkg;

    typedef enum logic [1:0] {
        MCR_PIN3_ATTN_OUT = 2'h0,
        MCR_PIN3_GP_OUT = 2'h1,
        MCR_PIN3_IN_LOW = 2'h2,
        MCR_PIN3_IN_HIGH = 2'h3
    } mcr_pin3_mode_type;

endpackage : mcr_pkg

/* bench/mcr_top_props.sv */
// port assertions for the monitor register block
`timescale 1ns/100ps
module mcr_top_props
    import mcr_pkg::*;
#(
    parameter logic [15:0] SPECIAL_IDENT = 16'h5a5a // arbitrary value
) (
    input wire logic mclk_i, // clock
    input wire logic reset_i, // reset
    input wire logic [7:0] reg_addr_i, // address
    input wire logic reg_rd_i, // read strobe
    input wire logic [7:0] reg_rdata_o, // read data
    input wire logic reg_rvalid_o, // read valid
    input wire logic alert_event_i, // alert
    input wire mcr_pkg::mcr_pin3_mode_type pin3_mode_i, // pin mode
    input wire logic pin3_o, // pin level
    input wire logic pin3_oe_o, // pin enable
    input wire logic use_int_osc_i, // osc select
    input wire logic int_osc_tick_i, // osc tick
    input wire logic sys_tick_o, // system tick
    input wire logic [1:0] conv_timing_hi_i, // high field
    input wire logic [2:0] conv_timing_lo_i, // low field
    input wire logic [25:0] n_factor_o // factor n
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    a_read_answers: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read got no valid");
    a_conv_low_zero: assert property (reg_rd_i && reg_addr_i == 8'h01 |=> reg_rdata_o[3:0] == 4'h0)
        else $error("low nibble not zero");
    a_ctrl_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 8'h42 |=> reg_rdata_o[5:0] == 6'h00)
        else $error("control reserved bits set");
    a_div_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 8'h43 |=> reg_rdata_o[7:5] == 3'h0)
        else $error("divider reserved bits set");
    a_pin_drives_low: assert property (!pin3_o)
        else $error("pin driven high");
    a_attn_pulls_low: assert property (alert_event_i && pin3_mode_i == MCR_PIN3_ATTN_OUT ##1 pin3_mode_i == MCR_PIN3_ATTN_OUT |=> pin3_oe_o)
        else $error("alert did not pull pin");
    a_input_mode_idle: assert property ($past(pin3_mode_i[1]) |-> !pin3_oe_o)
        else $error("pin pulled in input mode");
    a_int_osc_tick: assert property (use_int_osc_i [*3] |-> sys_tick_o == $past(int_osc_tick_i))
        else $error("internal tick not passed");
    a_n_low_110: assert property (conv_timing_lo_i == 3'h6 |=> n_factor_o == 26'd40985000)
        else $error("n wrong for low 110");
    a_n_00_011: assert property (conv_timing_hi_i == 2'h0 && conv_timing_lo_i == 3'h3 |=> n_factor_o == 26'd40990000)
        else $error("n wrong for 00 011");
endmodule : mcr_top_props

/* bench/mcr_host.sv */
// host model driving the register port
`timescale 1ns/100ps
module mcr_host (
    input wire logic mclk_i, // clock
    input wire logic [7:0] reg_rdata_i, // read data
    input wire logic reg_rvalid_i, // read valid
    output logic [7:0] reg_addr_o, // address
    output logic reg_wr_o, // write strobe
    output logic reg_rd_o, // read strobe
    output logic [7:0] reg_wdata_o // write data
);
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // idle lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge mclk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : wr
    // data and valid stand from the edge after the strobe to the next edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge mclk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge mclk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        v = reg_rvalid_i;
        d = reg_rdata_i;
    endtask : rd
endmodule : mcr_host

/* bench/tb_mcr_top.sv */
// self-checking bench for the monitor register block
`timescale 1ns/100ps
module tb_mcr_top;
    import mcr_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, pin3_o, pin3_oe_o, sys_tick_o;
    logic alert_event_i = 1'b0, ext_clock_in_i = 1'b0, use_int_osc_i = 1'b0, int_osc_tick_i = 1'b0;
    mcr_pin3_mode_type pin3_mode_i = MCR_PIN3_ATTN_OUT;
    logic [1:0] conv_timing_hi_i = 2'h0;
    logic [2:0] conv_timing_lo_i = 3'h3;
    logic [25:0] n_factor_o;
    logic [33:0] lsb_time_o;
    logic [11:0] conv_value_i = 12'habc;
    logic [23:0] power_value_i = 24'h123456;
    logic [31:0] accum_value_i = 32'h89abcdef;
    int err_count = 0, checked = 0;
    wire logic pin3_i;
    assign pin3_i = pin3_oe_o ? pin3_o : 1'b1; // board pull-up
    initial forever #50 mclk_i = ~mclk_i;
    // external time base at a quarter of the block clock
    initial forever
    begin
        repeat (2) @(negedge mclk_i);
        ext_clock_in_i = ~ext_clock_in_i;
    end
    mcr_top u_dut (.mclk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .reg_rvalid_o, .alert_event_i, .pin3_mode_i, .pin3_i, .pin3_o,
        .pin3_oe_o, .ext_clock_in_i, .use_int_osc_i, .int_osc_tick_i, .sys_tick_o,
        .conv_timing_hi_i, .conv_timing_lo_i, .n_factor_o, .lsb_time_o, .conv_value_i,
        .power_value_i, .accum_value_i);
    mcr_host u_host (.mclk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
        .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        u_host.rd(a, d, v);
        chk(v, 1'b1);
        chk(d, exp);
    endtask : rdchk
    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic t_regs;
        rdchk(8'h42, 8'h00);
        rdchk(8'h43, 8'h04);
        rdchk(8'h30, 8'h00);
        rdchk(8'h00, 8'hab);
        rdchk(8'h01, 8'hc0);
        for (int i = 0; i < 3; i++)
            rdchk(8'(2 + i), 8'(power_value_i >> (16 - 8 * i)));
        for (int i = 0; i < 4; i++)
            rdchk(8'(5 + i), 8'(accum_value_i >> (24 - 8 * i)));
    endtask : t_regs
    task automatic t_flag;
        @(negedge mclk_i) alert_event_i = 1'b1;
        @(negedge mclk_i) alert_event_i = 1'b0;
        rdchk(8'h42, 8'h80);
        chk(pin3_i, 1'b0);
        u_host.wr(8'h42, 8'h7f);
        rdchk(8'h42, 8'h40);
        chk(pin3_i, 1'b1);
        pin3_mode_i = MCR_PIN3_GP_OUT;
        rdchk(8'h42, 8'h40);
        chk(pin3_i, 1'b0);
        u_host.wr(8'h42, 8'h80);
        rdchk(8'h42, 8'h80);
        chk(pin3_i, 1'b1);
        pin3_mode_i = MCR_PIN3_IN_LOW;
        u_host.wr(8'h42, 8'hc0);
        rdchk(8'h42, 8'hc0);
        chk(pin3_i, 1'b1);
        // alert and a clearing write in one cycle: the alert wins
        fork
            u_host.wr(8'h42, 8'h00);
            @(negedge mclk_i) alert_event_i = 1'b1;
        join
        alert_event_i = 1'b0;
        rdchk(8'h42, 8'h80);
        u_host.wr(8'h42, 8'h00);
        rdchk(8'h42, 8'h00);
    endtask : t_flag
    task automatic t_div;
        time t0;
        u_host.wr(8'h43, 8'he2);
        rdchk(8'h43, 8'h02);
        for (int k = 0; k < 2; k++)
        begin
            t0 = $time;
            @(negedge mclk_i);
            repeat (100)
            begin
                @(negedge mclk_i);
                if (sys_tick_o === 1'b1)
                    break;
            end
        end
        chk(34'($time - t0), 34'd3200);
        chk(n_factor_o, 26'd40990000);
        chk(lsb_time_o, 34'd327920000);
        use_int_osc_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        int_osc_tick_i = 1'b1;
        @(negedge mclk_i) int_osc_tick_i = 1'b0;
        chk(sys_tick_o, 1'b1);
        chk(lsb_time_o, 34'd163960000);
        conv_timing_hi_i = 2'h2;
        conv_timing_lo_i = 3'h6;
        repeat (3) @(negedge mclk_i);
        chk(n_factor_o, 26'd40985000);
    endtask : t_div
    initial
    begin
        #500000;
        err_count++;
        stop_test;
    end
    initial
    begin
        repeat (3) @(negedge mclk_i);
        reset_i = 1'b0;
        t_regs;
        t_flag;
        t_div;
        stop_test;
    end
endmodule : tb_mcr_top
bind mcr_top mcr_top_props #(.SPECIAL_IDENT(SPECIAL_IDENT)) u_props (.mclk_i, .reset_i,
    .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .alert_event_i, .pin3_mode_i,
    .pin3_o, .pin3_oe_o, .use_int_osc_i, .int_osc_tick_i, .sys_tick_o, .conv_timing_hi_i,
    .conv_timing_lo_i, .n_factor_o);
